// ===== pic_pkg.sv
// Package: constants and types for the priority interrupt controller
package pic_pkg;
   localparam int NSRC = 14;
   localparam int AW = 8;
   localparam int DW = 16;
   localparam int LVW = 4;
   localparam int CW = 12;
   localparam int XW = 32;
   // Register byte offsets
   localparam logic [7:0] OFF_PRIO_A = 8'h00;
   localparam logic [7:0] OFF_PRIO_B = 8'h04;
   localparam logic [7:0] OFF_NMI_CTRL = 8'h08;
   localparam logic [7:0] OFF_EVT_CODE = 8'h0C;
   // Reset values
   localparam logic [15:0] PRIO_RST = 16'h0000;
   localparam logic NMI_EDGE_RST = 1'b0;
   // Control register fields and priority register B write mask
   localparam int NMI_LEVEL_BIT = 15;
   localparam int NMI_EDGE_BIT = 8;
   localparam logic [15:0] PRIO_B_WMASK = 16'hFFF0;
   // Core status register fields
   localparam int ST_MD_BIT = 30;
   localparam int ST_RB_BIT = 29;
   localparam int ST_BL_BIT = 28;
   localparam int ST_IMASK_LO = 4;
   // Event codes and vector offset
   localparam logic [11:0] CODE_NMI = 12'h1C0;
   localparam logic [11:0] CODE_BASE = 12'h400;
   localparam logic [11:0] CODE_STEP = 12'h020;
   localparam logic [31:0] VEC_OFFSET = 32'h00000600;
   // Level field index per source: {reg B?, nibble}, in default ranking order
   localparam logic [2:0] SRC_FIELD [NSRC] = '{
      3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0,
      3'h5, 3'h5, 3'h5, 3'h5, 3'h7, 3'h6, 3'h6};
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } pic_bus_t;
   typedef struct packed {
      logic [XW-1:0] status;
      logic [XW-1:0] pc;
      logic [XW-1:0] vector_base_reg;
      logic boundary;
   } pic_core_t;
endpackage

// ===== pic_top.sv
// Priority interrupt controller with core exception-entry sequencing
//
// Overview of operation
// - Both priority registers are 16-bit read/write, reset to zero, kept in standby.
// - Four 4-bit level fields per register, each serving one source group, except the lowest field of register B.
// - Level zero masks a group; fifteen is the highest priority.
// - Lowest field of register B reads zero; software writes zero there.
// - Control register is 16 bits, reset-initialised, unchanged in standby.
// - Control bit 15 reads the live non-maskable pin level; writes ignored.
// - Control bit 8 picks edge: zero falling (reset), one rising.
// - Control bits 14-9 and 7-0 read zero; software writes zero.
// - Highest programmed level wins; lower requests stay pending.
// - Ties resolve by fixed default ranking and in-field ranking.
// - Accept only when selected level is strictly above the core mask.
// - Accepted-interrupt pin goes low and stays low while request stands.
// - Pin returns high once masked; pin ignores the block bit.
// - Interrupt is taken only at an instruction boundary.
// - Winning source code loads into the event code register on taking.
// - Taking copies status and program counter into the saved registers.
// - Taking leaves the mask level bits unchanged.
// - Fetch address is vector base plus a fixed offset.
// - Nesting: handler saves context, unblocks, raises mask to accepted level.
// - While block bit is one, taking waits until it clears.
//
// Implementation choices: the placing of the registers and the strobed register port.
module pic_top
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire pic_bus_t bus,
   output logic [DW-1:0] rdata,
   input wire logic [NSRC-1:0] src_req,
   input wire logic nmi_pin,
   input wire pic_core_t core,
   output logic irq_accepted_out_n,
   output logic take_pulse,
   output logic [CW-1:0] event_code_reg,
   output logic [XW-1:0] saved_status_reg,
   output logic [XW-1:0] saved_pc_reg,
   output logic [XW-1:0] new_status,
   output logic [XW-1:0] fetch_addr
);

   logic [DW-1:0] prio_a_r;
   logic [DW-1:0] prio_b_r;
   logic nmi_edge_sel_r;
   logic nmi_s1_r;
   logic nmi_s2_r;
   logic nmi_s3_r;
   logic nmi_pend_r;
   logic nmi_edge;
   logic [LVW-1:0] sel_level;
   logic [CW-1:0] sel_code;
   logic sel_valid;
   logic [LVW-1:0] sel_level_r;
   logic [CW-1:0] sel_code_r;
   logic accept_r;
   logic block_bit;
   logic [LVW-1:0] mask_level_bits;
   logic take;
   logic [DW-1:0] rdata_nxt;

   // Level field of one source from the two priority registers
   function automatic logic [LVW-1:0] field_level(
      input logic [2:0] f,
      input logic [DW-1:0] a,
      input logic [DW-1:0] b
   );
      logic [DW-1:0] r;
      r = f[2] ? b : a;
      field_level = r[f[1:0]*LVW +: LVW];
   endfunction

   assign block_bit = core.status[ST_BL_BIT];
   assign mask_level_bits = core.status[ST_IMASK_LO +: LVW];

   // Priority registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prio_a_r <= PRIO_RST;
         prio_b_r <= PRIO_RST;
      end else if (bus.wr) begin
         if (bus.addr == OFF_PRIO_A) begin
            prio_a_r <= bus.wdata;
         end
         if (bus.addr == OFF_PRIO_B) begin
            prio_b_r <= bus.wdata & PRIO_B_WMASK;
         end
      end
   end

   // Control register edge select
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_edge_sel_r <= NMI_EDGE_RST;
      end else if (bus.wr && bus.addr == OFF_NMI_CTRL) begin
         nmi_edge_sel_r <= bus.wdata[NMI_EDGE_BIT];
      end
   end

   // Pin synchroniser and edge history
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         nmi_s3_r <= 1'b0;
      end else begin
         nmi_s1_r <= nmi_pin;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
      end
   end

   assign nmi_edge = nmi_edge_sel_r ? (nmi_s2_r & ~nmi_s3_r)
                                    : (~nmi_s2_r & nmi_s3_r);

   // Pending edge request, new edge wins over the take
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_pend_r <= 1'b0;
      end else if (nmi_edge) begin
         nmi_pend_r <= 1'b1;
      end else if (take) begin
         nmi_pend_r <= 1'b0;
      end
   end

   // Arbitration across sources in ranking order
   always_comb begin
      sel_level = '0;
      sel_code = '0;
      sel_valid = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (src_req[i] &&
             field_level(SRC_FIELD[i], prio_a_r, prio_b_r) != '0 &&
             field_level(SRC_FIELD[i], prio_a_r, prio_b_r) > sel_level) begin
            sel_level = field_level(SRC_FIELD[i], prio_a_r, prio_b_r);
            sel_code = CODE_BASE + CW'(i) * CODE_STEP;
            sel_valid = 1'b1;
         end
      end
   end

   // Mask compare and accepted-interrupt pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_level_r <= '0;
         sel_code_r <= '0;
         accept_r <= 1'b0;
         irq_accepted_out_n <= 1'b1;
      end else begin
         sel_level_r <= sel_level;
         sel_code_r <= sel_code;
         accept_r <= sel_valid && (sel_level > mask_level_bits);
         irq_accepted_out_n <= ~(sel_valid && (sel_level > mask_level_bits));
      end
   end

   // Take at boundary while unblocked; the edge request outranks all
   assign take = core.boundary && !block_bit && (nmi_pend_r || accept_r);

   // Exception entry
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         take_pulse <= 1'b0;
         event_code_reg <= '0;
         saved_status_reg <= '0;
         saved_pc_reg <= '0;
         new_status <= '0;
         fetch_addr <= '0;
      end else begin
         take_pulse <= take;
         if (take) begin
            event_code_reg <= nmi_pend_r ? CODE_NMI : sel_code_r;
            saved_status_reg <= core.status;
            saved_pc_reg <= core.pc;
            new_status <= core.status | (XW'(1) << ST_BL_BIT)
                          | (XW'(1) << ST_MD_BIT) | (XW'(1) << ST_RB_BIT);
            fetch_addr <= core.vector_base_reg + VEC_OFFSET;
         end
      end
   end

   // Read decode
   always_comb begin
      rdata_nxt = '0;
      case (bus.addr)
         OFF_PRIO_A: rdata_nxt = prio_a_r;
         OFF_PRIO_B: rdata_nxt = prio_b_r;
         OFF_NMI_CTRL: begin
            rdata_nxt[NMI_LEVEL_BIT] = nmi_s2_r;
            rdata_nxt[NMI_EDGE_BIT] = nmi_edge_sel_r;
         end
         OFF_EVT_CODE: rdata_nxt = DW'(event_code_reg);
         default: rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (bus.rd) begin
         rdata <= rdata_nxt;
      end else begin
         rdata <= '0;
      end
   end

endmodule

// ===== pic_monitor.sv
// Checker on the controller top ports
module pic_monitor
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire pic_bus_t bus,
   input wire logic [DW-1:0] rdata,
   input wire logic [NSRC-1:0] src_req,
   input wire logic nmi_pin,
   input wire pic_core_t core,
   input wire logic irq_accepted_out_n,
   input wire logic take_pulse,
   input wire logic [CW-1:0] event_code_reg,
   input wire logic [XW-1:0] saved_status_reg,
   input wire logic [XW-1:0] saved_pc_reg,
   input wire logic [XW-1:0] new_status,
   input wire logic [XW-1:0] fetch_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_take_boundary: assert property (!core.boundary |=> !take_pulse)
      else $error("take off boundary");
   a_take_blocked: assert property (core.status[ST_BL_BIT] |=> !take_pulse)
      else $error("take while blocked");
   a_saved_ctx: assert property (take_pulse |-> saved_pc_reg == $past(core.pc)
      && saved_status_reg == $past(core.status)) else $error("saved context wrong");
   a_new_status: assert property (take_pulse |->
      new_status == ($past(core.status) | 32'h70000000)) else $error("new status wrong");
   a_vector: assert property (take_pulse |-> fetch_addr == $past(core.vector_base_reg) + VEC_OFFSET)
      else $error("fetch address wrong");
   a_take_cause: assert property (take_pulse |->
      !$past(irq_accepted_out_n) || event_code_reg == CODE_NMI) else $error("take uncaused");
   a_ctrl_zero: assert property (bus.rd && bus.addr == OFF_NMI_CTRL |=>
      rdata[14:9] == 6'h00 && rdata[7:0] == 8'h00) else $error("control spare bits set");
   a_prio_b_low: assert property (bus.rd && bus.addr == OFF_PRIO_B |=> rdata[3:0] == 4'h0)
      else $error("spare field set");
   cover property (take_pulse && event_code_reg == CODE_NMI);
   cover property (!irq_accepted_out_n && core.status[ST_BL_BIT]);
   cover property (bus.wr && bus.addr == OFF_NMI_CTRL);
endmodule
bind pic_top pic_monitor i_mon (.*);

// ===== pic_core_model.sv
// Core model: status, program counter, boundary
module pic_core_model
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic take_pulse,
   input wire logic [XW-1:0] new_status,
   input wire logic [XW-1:0] fetch_addr,
   input wire logic sr_load,
   input wire logic [XW-1:0] sr_val,
   output pic_core_t core
);
   logic [XW-1:0] st_r;
   logic [XW-1:0] pc_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= 32'h700000F0;
         pc_r <= 32'hA0000000;
      end else if (take_pulse) begin
         st_r <= new_status;
         pc_r <= fetch_addr;
      end else begin
         if (sr_load) st_r <= sr_val;
         pc_r <= pc_r + 32'h2;
      end
   end
   assign core = '{status: st_r, pc: pc_r, vector_base_reg: 32'h8C000000, boundary: pc_r[1]};
endmodule

// ===== pic_top_test.sv
// Testbench for the priority interrupt controller
module pic_top_test;
   import pic_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0;
   logic arst_n = 0;
   pic_bus_t bus = '0;
   logic [NSRC-1:0] src_req = '0;
   logic nmi_pin = 1;
   logic sr_load = 0;
   logic [XW-1:0] sr_val = '0;
   pic_core_t core;
   logic [DW-1:0] rdata;
   logic irq_n, take;
   logic [CW-1:0] code;
   logic [XW-1:0] s_st, s_pc, n_st, f_ad;
   int n_mismatch = 0;
   int checks_done = 0;
   pic_top i_dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .src_req(src_req),
      .nmi_pin(nmi_pin), .core(core), .irq_accepted_out_n(irq_n), .take_pulse(take),
      .event_code_reg(code), .saved_status_reg(s_st), .saved_pc_reg(s_pc),
      .new_status(n_st), .fetch_addr(f_ad));
   pic_core_model i_core (.clk(clk), .arst_n(arst_n), .take_pulse(take), .new_status(n_st),
      .fetch_addr(f_ad), .sr_load(sr_load), .sr_val(sr_val), .core(core));
   always #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      bus <= {a, w ? d : 16'h0, w, !w};
      @(posedge clk);
      bus <= '0;
      #1 if (!w) chk(rdata, d);
      @(posedge clk);
   endtask
   task automatic hit(input logic bl, input logic [3:0] m, input logic [13:0] req,
      input logic [11:0] exp, input logic irq);
      int i;
      // Block first, change requests, let arbitration settle, then load the block bit from bl
      sr_val <= {3'h2, 1'b1, 20'h0, m, 4'h0};
      sr_load <= 1'b1;
      @(posedge clk);
      sr_load <= 1'b0;
      src_req <= req;
      repeat (2) @(posedge clk);
      sr_val <= {3'h2, bl, 20'h0, m, 4'h0};
      sr_load <= 1'b1;
      @(posedge clk);
      sr_load <= 1'b0;
      for (i = 0; i < 12 && take !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(take, exp != 12'h0);
      if (take !== (exp != 12'h0)) tally_and_finish();
      if (exp != 12'h0) chk(code, exp);
      chk(irq_n, irq);
      $display("case %h done", exp);
      @(posedge clk);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      acc(0, OFF_PRIO_A, 16'h0000);
      acc(0, OFF_NMI_CTRL, 16'h8000);
      acc(1, OFF_PRIO_B, 16'hFFFF);
      acc(0, OFF_PRIO_B, 16'hFFF0);
      acc(1, OFF_NMI_CTRL, 16'hFFFF);
      acc(0, OFF_NMI_CTRL, 16'h8100);
      acc(0, 8'h10, 16'h0000);
      acc(1, OFF_PRIO_A, 16'h1230);
      acc(0, OFF_PRIO_A, 16'h1230);
      acc(1, OFF_PRIO_B, 16'h5670);
      acc(1, OFF_NMI_CTRL, 16'h0000);
      hit(0, 4'h0, 14'h0003, 12'h420, 0);
      hit(0, 4'h0, 14'h0001, 12'h400, 0);
      hit(0, 4'h0, 14'h000C, 12'h440, 0);
      hit(0, 4'h0, 14'h0070, 12'h000, 1);
      hit(0, 4'h6, 14'h3FFF, 12'h4E0, 0);
      hit(0, 4'h4, 14'h1800, 12'h580, 0);
      hit(1, 4'h0, 14'h0001, 12'h000, 0);
      hit(1, 4'h1, 14'h0001, 12'h000, 1);
      hit(1, 4'h0, 14'h0000, 12'h000, 1);
      nmi_pin <= 1'b0;
      hit(0, 4'hF, 14'h0000, 12'h1C0, 1);
      acc(1, OFF_NMI_CTRL, 16'h0100);
      nmi_pin <= 1'b1;
      hit(0, 4'hF, 14'h0000, 12'h1C0, 1);
      acc(0, OFF_NMI_CTRL, 16'h8100);
      tally_and_finish();
   end
endmodule
